// ### core/sbc_regs_pkg.sv
// constants, types and helpers for the watchdog/status and mode registers
//
// Functional notes
// R1: bit 12 reports read-only access; read-only frames leave contents as they are.
// R2: in Normal mode watchdog mode bit 0 gives Window, 1 gives Timeout.
// R3: in Standby mode watchdog mode bit 0 gives Timeout, 1 turns it off.
// R4: period codes 0..7 give 8..4096 ms; code returns to 100 on reset.
// R5: bit 7 follows the watchdog-disable pin; setting it fires a soft reset.
// R6: bit 6 is 1 while the main regulator is under voltage.
// R7: bit 5 is 1 while the transceiver regulator is under voltage.
// R8: bit 4 follows the level of the first local wake input.
// R9: bit 3 follows the level of the second local wake input.
// R10: frame bits 15:13 select register, bit 12 is the read-only flag.
// R11: mode field bits 11:10: Standby, Sleep, Normal off, Normal on.
// R12: full duplex: register contents shift out while control data shifts in.
// R13: reserved bits 2:0 of the watchdog register read zero, writes ignored.
package sbc_regs_pkg;

  // ----------------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] FRAME_LEN_SAT = 5'h11;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 13;
  localparam int RDONLY_BIT = 12;
  localparam logic [2:0] REG_WATCHDOG = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int MODE_SEL_BIT = 11;
  localparam int PERIOD_MSB = 10;
  localparam int PERIOD_LSB = 8;
  localparam int SOFT_RST_BIT = 7;
  localparam int UV_MAIN_BIT = 6;
  localparam int UV_XCVR_BIT = 5;
  localparam int WAKE_A_BIT = 4;
  localparam int WAKE_B_BIT = 3;
  localparam int OPMODE_MSB = 11;
  localparam int OPMODE_LSB = 10;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] PERIOD_RESET = 3'h4;
  localparam logic MODE_SEL_RESET = 1'h0;
  localparam logic RDONLY_RESET = 1'h0;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // ----------------------------------------------------------------------
  // pin synchroniser lanes
  // ----------------------------------------------------------------------
  localparam int SYNC_W = 6;
  localparam int SY_CS = 5;
  localparam int SY_DISABLE = 4;
  localparam int SY_UV1 = 3;
  localparam int SY_UV2 = 2;
  localparam int SY_WAKE_A = 1;
  localparam int SY_WAKE_B = 0;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h20;

  // ----------------------------------------------------------------------
  // nominal watchdog periods in ms
  // ----------------------------------------------------------------------
  localparam logic [12:0] PERIOD_MS_0 = 13'h0008;
  localparam logic [12:0] PERIOD_MS_1 = 13'h0010;
  localparam logic [12:0] PERIOD_MS_2 = 13'h0020;
  localparam logic [12:0] PERIOD_MS_3 = 13'h0040;
  localparam logic [12:0] PERIOD_MS_4 = 13'h0080;
  localparam logic [12:0] PERIOD_MS_5 = 13'h0100;
  localparam logic [12:0] PERIOD_MS_6 = 13'h0400;
  localparam logic [12:0] PERIOD_MS_7 = 13'h1000;

  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_NORMAL_XOFF = 2'b10,
    MODE_NORMAL_XON = 2'b11
  } operating_mode_type;

  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_WINDOW = 2'b01,
    WD_TIMEOUT = 2'b10
  } wd_op_type;

  localparam operating_mode_type MODE_RESET = MODE_STANDBY;

  // code to period lookup
  function automatic logic [12:0] period_ms(input logic [2:0] code);
    case (code)
      3'h0: period_ms = PERIOD_MS_0;
      3'h1: period_ms = PERIOD_MS_1;
      3'h2: period_ms = PERIOD_MS_2;
      3'h3: period_ms = PERIOD_MS_3;
      3'h4: period_ms = PERIOD_MS_4;
      3'h5: period_ms = PERIOD_MS_5;
      3'h6: period_ms = PERIOD_MS_6;
      default: period_ms = PERIOD_MS_7;
    endcase
  endfunction : period_ms

endpackage : sbc_regs_pkg

// ### core/spi_link_if.sv
// words crossing between the register logic and the serial link logic
`timescale 1ns/10ps
interface spi_link_if;
  // image to send; stable while a frame runs
  logic [15:0] tx_word;
  // last frame received and its bit count; stable once select is high
  logic [15:0] rx_word;
  logic [4:0] rx_len;
  modport sys_side (output tx_word, input rx_word, input rx_len);
  modport link_side (input tx_word, output rx_word, output rx_len);
endinterface : spi_link_if

// ### core/spi_link_shifter.sv
// serial shifter running on the link clock
`timescale 1ns/10ps
module spi_link_shifter (
  spi_link_if.link_side link,
  input wire logic spi_sck,
  input wire logic spi_scsn_n,
  input wire logic spi_sdi,
  output logic spi_sdo
);

  logic [4:0] cnt_q;
  logic [14:0] tx_sh_q;
  logic [15:0] rx_q;
  logic [4:0] len_q;

  assign link.rx_word = rx_q;
  assign link.rx_len = len_q;

  // ----------------------------------------------------------------------
  // receive side, sampled on the falling edge
  // ----------------------------------------------------------------------
  // counter cleared by the frame's own select; clock is idle then
  always_ff @(negedge spi_sck or posedge spi_scsn_n) begin
    if (spi_scsn_n) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != sbc_regs_pkg::FRAME_LEN_SAT) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // no reset: the word must survive until the register side takes it
  always_ff @(negedge spi_sck) begin
    rx_q <= {rx_q[14:0], spi_sdi}; // R12
    if (cnt_q != sbc_regs_pkg::FRAME_LEN_SAT) begin
      len_q <= cnt_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // transmit side, shifted on the rising edge
  // ----------------------------------------------------------------------
  // first rising edge loads the image, msb first
  always_ff @(posedge spi_sck or posedge spi_scsn_n) begin
    if (spi_scsn_n) begin
      spi_sdo <= 1'b0;
      tx_sh_q <= 15'h0000;
    end else if (cnt_q == 5'h00) begin
      spi_sdo <= link.tx_word[15]; // R12
      tx_sh_q <= link.tx_word[14:0];
    end else begin
      spi_sdo <= tx_sh_q[14];
      tx_sh_q <= {tx_sh_q[13:0], 1'b0};
    end
  end

endmodule : spi_link_shifter

// ### core/sbc_watchdog_status_mode_regs.sv
// watchdog/status and mode control registers behind the serial link
`timescale 1ns/10ps
module sbc_watchdog_status_mode_regs (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic spi_sck,
  input wire logic spi_scsn_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  input wire logic watchdog_disable_pin,
  input wire logic main_reg_below_uv,
  input wire logic xcvr_reg_below_uv,
  input wire logic first_local_wake_input,
  input wire logic second_local_wake_input,
  output sbc_regs_pkg::operating_mode_type operating_mode_select,
  output logic watchdog_mode_select,
  output logic [2:0] nominal_period_code,
  output logic [12:0] nominal_period_ms,
  output sbc_regs_pkg::wd_op_type watchdog_op,
  output logic soft_reset_pulse
);

  spi_link_if link ();

  logic [sbc_regs_pkg::SYNC_W-1:0] sync1_q;
  logic [sbc_regs_pkg::SYNC_W-1:0] sync2_q;
  logic [sbc_regs_pkg::SYNC_W-1:0] sync3_q;
  logic [sbc_regs_pkg::SYNC_W-1:0] filt_q;
  logic [sbc_regs_pkg::SYNC_W-1:0] raw_pins;
  logic cs_prev_q;
  logic disable_prev_q;
  logic frame_done;
  logic frame_valid;
  logic [2:0] rx_addr;
  logic rx_rdonly;
  logic rw_wd;
  logic rw_mode;
  logic wd_rdonly_q;
  logic mode_rdonly_q;
  logic [2:0] last_addr_q;
  logic [15:0] tx_word_q;
  logic [15:0] tx_word_d;

  // ----------------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------------
  spi_link_shifter shifter (
    .link(link.link_side),
    .spi_sck(spi_sck),
    .spi_scsn_n(spi_scsn_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo)
  );

  assign link.tx_word = tx_word_q;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  assign raw_pins = {spi_scsn_n, watchdog_disable_pin, main_reg_below_uv,
                     xcvr_reg_below_uv, first_local_wake_input,
                     second_local_wake_input};

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_q <= sbc_regs_pkg::SYNC_RESET;
      sync2_q <= sbc_regs_pkg::SYNC_RESET;
      sync3_q <= sbc_regs_pkg::SYNC_RESET;
      filt_q <= sbc_regs_pkg::SYNC_RESET;
    end else begin
      sync1_q <= raw_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
    end
  end

  // edge history for select and watchdog-disable pin
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cs_prev_q <= 1'b1;
      disable_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= filt_q[sbc_regs_pkg::SY_CS];
      disable_prev_q <= filt_q[sbc_regs_pkg::SY_DISABLE];
    end
  end

  // sdo released until select is seen low; costs five cycles of setup
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      spi_sdo_oe_n <= 1'b1;
    end else begin
      spi_sdo_oe_n <= filt_q[sbc_regs_pkg::SY_CS];
    end
  end

  // ----------------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------------
  // link words are quiet once select is high: no clock edges arrive then
  assign frame_done = filt_q[sbc_regs_pkg::SY_CS] & ~cs_prev_q;
  assign frame_valid = frame_done &&
                       (link.rx_len == sbc_regs_pkg::FRAME_LEN);
  assign rx_addr = link.rx_word[sbc_regs_pkg::ADDR_MSB:
                                sbc_regs_pkg::ADDR_LSB]; // R10
  assign rx_rdonly = link.rx_word[sbc_regs_pkg::RDONLY_BIT]; // R10
  assign rw_wd = frame_valid && !rx_rdonly &&
                 (rx_addr == sbc_regs_pkg::REG_WATCHDOG); // R1
  assign rw_mode = frame_valid && !rx_rdonly &&
                   (rx_addr == sbc_regs_pkg::REG_MODE); // R1

  // access status per register, taken from every valid frame
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wd_rdonly_q <= sbc_regs_pkg::RDONLY_RESET;
      mode_rdonly_q <= sbc_regs_pkg::RDONLY_RESET;
      last_addr_q <= sbc_regs_pkg::REG_WATCHDOG;
    end else if (frame_valid) begin
      last_addr_q <= rx_addr;
      if (rx_addr == sbc_regs_pkg::REG_WATCHDOG) begin
        wd_rdonly_q <= rx_rdonly; // R1
      end
      if (rx_addr == sbc_regs_pkg::REG_MODE) begin
        mode_rdonly_q <= rx_rdonly; // R1
      end
    end
  end

  // ----------------------------------------------------------------------
  // writable fields
  // ----------------------------------------------------------------------
  // watchdog mode and period; reserved bits are dropped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      watchdog_mode_select <= sbc_regs_pkg::MODE_SEL_RESET;
      nominal_period_code <= sbc_regs_pkg::PERIOD_RESET; // R4
    end else if (rw_wd) begin
      watchdog_mode_select <= link.rx_word[sbc_regs_pkg::MODE_SEL_BIT]; // R2
      nominal_period_code <= link.rx_word[sbc_regs_pkg::PERIOD_MSB:
                                          sbc_regs_pkg::PERIOD_LSB]; // R4
    end
  end

  // mode field; only the two mode bits of this register are kept
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      operating_mode_select <= sbc_regs_pkg::MODE_RESET;
    end else if (rw_mode) begin
      operating_mode_select <= sbc_regs_pkg::operating_mode_type'(
        link.rx_word[sbc_regs_pkg::OPMODE_MSB:sbc_regs_pkg::OPMODE_LSB]); // R11
    end
  end

  // soft reset on a written 1 or on the pin going high
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= (rw_wd &&
                           link.rx_word[sbc_regs_pkg::SOFT_RST_BIT]) ||
                          (filt_q[sbc_regs_pkg::SY_DISABLE] &&
                           !disable_prev_q); // R5
    end
  end

  // period in ms for the watchdog timer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nominal_period_ms <=
        sbc_regs_pkg::period_ms(sbc_regs_pkg::PERIOD_RESET);
    end else begin
      nominal_period_ms <= sbc_regs_pkg::period_ms(nominal_period_code); // R4
    end
  end

  // resulting watchdog operation; the pin overrides the mode bit
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      watchdog_op <= sbc_regs_pkg::WD_TIMEOUT;
    end else if (filt_q[sbc_regs_pkg::SY_DISABLE]) begin
      watchdog_op <= sbc_regs_pkg::WD_OFF; // R5
    end else begin
      case (operating_mode_select)
        sbc_regs_pkg::MODE_NORMAL_XOFF, sbc_regs_pkg::MODE_NORMAL_XON: begin
          watchdog_op <= watchdog_mode_select ? sbc_regs_pkg::WD_TIMEOUT
                                              : sbc_regs_pkg::WD_WINDOW; // R2
        end
        sbc_regs_pkg::MODE_STANDBY: begin
          watchdog_op <= watchdog_mode_select ? sbc_regs_pkg::WD_OFF
                                              : sbc_regs_pkg::WD_TIMEOUT; // R3
        end
        default: begin
          watchdog_op <= sbc_regs_pkg::WD_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read image
  // ----------------------------------------------------------------------
  // assemble the word for a register address
  function automatic logic [15:0] read_word(input logic [2:0] addr);
    logic [15:0] w;
    w = sbc_regs_pkg::WORD_ZERO; // R13
    w[sbc_regs_pkg::ADDR_MSB:sbc_regs_pkg::ADDR_LSB] = addr; // R10
    case (addr)
      sbc_regs_pkg::REG_WATCHDOG: begin
        w[sbc_regs_pkg::RDONLY_BIT] = wd_rdonly_q; // R1
        w[sbc_regs_pkg::MODE_SEL_BIT] = watchdog_mode_select;
        w[sbc_regs_pkg::PERIOD_MSB:sbc_regs_pkg::PERIOD_LSB] =
          nominal_period_code;
        w[sbc_regs_pkg::SOFT_RST_BIT] = filt_q[sbc_regs_pkg::SY_DISABLE]; // R5
        w[sbc_regs_pkg::UV_MAIN_BIT] = filt_q[sbc_regs_pkg::SY_UV1]; // R6
        w[sbc_regs_pkg::UV_XCVR_BIT] = filt_q[sbc_regs_pkg::SY_UV2]; // R7
        w[sbc_regs_pkg::WAKE_A_BIT] = filt_q[sbc_regs_pkg::SY_WAKE_A]; // R8
        w[sbc_regs_pkg::WAKE_B_BIT] = filt_q[sbc_regs_pkg::SY_WAKE_B]; // R9
      end
      sbc_regs_pkg::REG_MODE: begin
        w[sbc_regs_pkg::RDONLY_BIT] = mode_rdonly_q; // R1
        w[sbc_regs_pkg::OPMODE_MSB:sbc_regs_pkg::OPMODE_LSB] =
          operating_mode_select;
      end
      default: begin
        w[sbc_regs_pkg::RDONLY_BIT] = 1'b0;
      end
    endcase
    return w;
  endfunction : read_word

  assign tx_word_d = read_word(last_addr_q);

  // image frozen while select is low so the link sees a steady word
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_word_q <= sbc_regs_pkg::WORD_ZERO;
    end else if (filt_q[sbc_regs_pkg::SY_CS] && !frame_done) begin
      tx_word_q <= tx_word_d; // R12
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_period_reset: assert property ($fell(reset) |->
    nominal_period_code == sbc_regs_pkg::PERIOD_RESET) // R4
    else $error("period code not 100 after reset");
  a_period_table: assert property (##1 nominal_period_ms ==
    sbc_regs_pkg::period_ms($past(nominal_period_code))) // R4
    else $error("period in ms does not match code");
  a_ro_keeps_wd: assert property (frame_valid && rx_rdonly &&
    rx_addr == sbc_regs_pkg::REG_WATCHDOG |=> wd_rdonly_q &&
    $stable(watchdog_mode_select) && $stable(nominal_period_code)) // R1
    else $error("read-only frame changed watchdog register");
  a_mode_write: assert property (rw_mode |=> operating_mode_select ==
    $past(link.rx_word[sbc_regs_pkg::OPMODE_MSB:
                       sbc_regs_pkg::OPMODE_LSB])) // R11
    else $error("mode field not written");
  a_wd_normal: assert property (!filt_q[sbc_regs_pkg::SY_DISABLE] &&
    operating_mode_select[1] |=> watchdog_op == ($past(watchdog_mode_select)
    ? sbc_regs_pkg::WD_TIMEOUT : sbc_regs_pkg::WD_WINDOW)) // R2
    else $error("wrong watchdog operation in normal mode");
  a_wd_standby: assert property (!filt_q[sbc_regs_pkg::SY_DISABLE] &&
    operating_mode_select == sbc_regs_pkg::MODE_STANDBY |=>
    watchdog_op == ($past(watchdog_mode_select) ? sbc_regs_pkg::WD_OFF
    : sbc_regs_pkg::WD_TIMEOUT)) // R3
    else $error("wrong watchdog operation in standby mode");
  a_pin_soft_reset: assert property (filt_q[sbc_regs_pkg::SY_DISABLE] &&
    !disable_prev_q |=> soft_reset_pulse ##1 watchdog_op ==
    sbc_regs_pkg::WD_OFF) // R5
    else $error("disable pin did not reset or stop watchdog");
  a_status_bits: assert property (filt_q[sbc_regs_pkg::SY_CS] &&
    !frame_done && last_addr_q == sbc_regs_pkg::REG_WATCHDOG |=>
    tx_word_q[7:0] == {$past(filt_q[4:1]), $past(filt_q[0]), 3'h0}) // R6
    else $error("status bits in read image wrong");
  a_wake_order: assert property (filt_q[sbc_regs_pkg::SY_CS] &&
    !frame_done && last_addr_q == sbc_regs_pkg::REG_WATCHDOG |=>
    tx_word_q[sbc_regs_pkg::WAKE_B_BIT] ==
    $past(filt_q[sbc_regs_pkg::SY_WAKE_B]) &&
    tx_word_q[15:12] == {sbc_regs_pkg::REG_WATCHDOG,
    $past(wd_rdonly_q)}) // R9
    else $error("wake level or header in read image wrong");
  a_tx_frozen: assert property (!filt_q[sbc_regs_pkg::SY_CS] |=>
    $stable(tx_word_q)) // R12
    else $error("read image changed during a frame");

  c_ro_frame: cover property (frame_valid && rx_rdonly);
  c_wd_write: cover property (rw_wd);
  c_mode_write: cover property (rw_mode ##1 operating_mode_select[1]);
  c_soft_reset: cover property (soft_reset_pulse);

endmodule : sbc_watchdog_status_mode_regs

// ### verification/spi_master_model.sv
// serial link master model standing in for the microcontroller
`timescale 1ns/10ps
module spi_master_model (
  input wire logic sys_clk,
  input wire logic sdo_wire,
  output logic sck,
  output logic scsn_n,
  output logic sdi
);
  // idle: select high, link clock parked low
  initial begin
    sck = 1'b0;
    scsn_n = 1'b1;
    sdi = 1'b0;
  end

  // one full-duplex frame, msb first; the link clock runs only inside it
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    @(negedge sys_clk);
    scsn_n = 1'b0;
    // more than 200 ns from select low to the first rising edge
    repeat (5) @(negedge sys_clk);
    for (i = 15; i >= 0; i--) begin
      // data moves well clear of the falling edge where it is sampled
      sdi = tx[i];
      #1.5 sck = 1'b1;
      #3 sck = 1'b0;
      rx[i] = sdo_wire;
      #1.5;
    end
    // released line shows the inverse so no stale bit passes for data
    sdi = ~sdi;
    @(negedge sys_clk);
    scsn_n = 1'b1;
    // gap covers the 400 ns minimum and the decode latency
    repeat (10) @(negedge sys_clk);
  endtask : xfer
endmodule : spi_master_model

// ### verification/testbench.sv
// self-checking bench for the watchdog/status and mode registers
`timescale 1ns/10ps
module testbench;
  logic sys_clk;
  logic reset;
  logic spi_sck;
  logic spi_scsn_n;
  logic spi_sdi;
  logic spi_sdo;
  logic spi_sdo_oe_n;
  logic sdo_wire;
  logic sdo_hold;
  logic [4:0] pins;
  sbc_regs_pkg::operating_mode_type operating_mode_select;
  logic watchdog_mode_select;
  logic [2:0] nominal_period_code;
  logic [12:0] nominal_period_ms;
  sbc_regs_pkg::wd_op_type watchdog_op;
  logic soft_reset_pulse;
  logic [15:0] rx;
  int mismatches;
  int checked;
  int pulses;
  int n;

  sbc_watchdog_status_mode_regs dut_u (
    .sys_clk(sys_clk),
    .reset(reset),
    .spi_sck(spi_sck),
    .spi_scsn_n(spi_scsn_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n),
    .watchdog_disable_pin(pins[4]),
    .main_reg_below_uv(pins[3]),
    .xcvr_reg_below_uv(pins[2]),
    .first_local_wake_input(pins[1]),
    .second_local_wake_input(pins[0]),
    .operating_mode_select(operating_mode_select),
    .watchdog_mode_select(watchdog_mode_select),
    .nominal_period_code(nominal_period_code),
    .nominal_period_ms(nominal_period_ms),
    .watchdog_op(watchdog_op),
    .soft_reset_pulse(soft_reset_pulse)
  );

  spi_master_model master_u (
    .sys_clk(sys_clk),
    .sdo_wire(sdo_wire),
    .sck(spi_sck),
    .scsn_n(spi_scsn_n),
    .sdi(spi_sdi)
  );

  // floating data line: inverse of the last driven bit
  initial sdo_hold = 1'b0;
  always @(posedge spi_sdo_oe_n) sdo_hold = ~spi_sdo;
  assign sdo_wire = spi_sdo_oe_n ? sdo_hold : spi_sdo;

  // clock generation
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // count soft reset pulses; a stuck pulse shows as an excess count
  initial pulses = 0;
  // sampled mid-cycle, where the pulse flop has settled
  always @(negedge sys_clk) begin
    if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
  end

  function automatic logic [15:0] period_exp(input int code);
    case (code)
      0: period_exp = 16'h0008;
      1: period_exp = 16'h0010;
      2: period_exp = 16'h0020;
      3: period_exp = 16'h0040;
      4: period_exp = 16'h0080;
      5: period_exp = 16'h0100;
      6: period_exp = 16'h0400;
      default: period_exp = 16'h1000;
    endcase
  endfunction : period_exp

  // sleep turns the watchdog off; mode bit meaning depends on the mode
  function automatic logic [15:0] op_exp(input int m, input int w);
    if (m == 1) op_exp = 16'h0000;
    else if (m == 0) op_exp = (w == 1) ? 16'h0000 : 16'h0002;
    else op_exp = (w == 1) ? 16'h0002 : 16'h0001;
  endfunction : op_exp

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  // pins pass three synchronising flops before they are seen
  task automatic set_pins(input logic [4:0] v);
    pins = v;
    repeat (8) @(negedge sys_clk);
  endtask : set_pins

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // hang guard, well beyond the roughly 32 us the tests take
  initial begin
    #200000;
    mismatches++;
    $display("FAIL at %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    reset = 1'b1;
    pins = 5'h00;
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    check_word({13'h0, nominal_period_code}, 16'h0004);
    check_word({3'h0, nominal_period_ms}, 16'h0080);
    check_word({15'h0, watchdog_mode_select}, 16'h0000);
    $display("test reset_values done");
    // status bits and read-only access
    set_pins(5'b01010);
    master_u.xfer(16'h1000, rx);
    check_word(rx, 16'h0450);
    set_pins(5'b00101);
    master_u.xfer(16'h1000, rx);
    check_word(rx, 16'h1428);
    check_word({13'h0, nominal_period_code}, 16'h0004);
    $display("test status_bits done");
    // every period code, reserved bits written as ones
    for (int i = 0; i < 8; i++) begin
      master_u.xfer(16'h0007 | (16'(i) << 8), rx);
      check_word({13'h0, nominal_period_code}, 16'(i));
      check_word({3'h0, nominal_period_ms}, period_exp(i));
    end
    master_u.xfer(16'h1000, rx);
    check_word(rx, 16'h0728);
    $display("test period_codes done");
    // unmapped address leaves everything alone
    master_u.xfer(16'h4FFF, rx);
    master_u.xfer(16'h1000, rx);
    check_word(rx, 16'h4000);
    check_word({13'h0, nominal_period_code}, 16'h0007);
    $display("test unmapped_address done");
    // every mode against both watchdog mode settings
    for (int w = 0; w < 2; w++) begin
      for (int m = 0; m < 4; m++) begin
        master_u.xfer(16'h0400 | (16'(w) << 11), rx);
        master_u.xfer(16'h23FF & ~16'h0C00 | (16'(m) << 10), rx);
        check_word(rx, 16'h0428 | (16'(w) << 11));
        check_word({14'h0, operating_mode_select}, 16'(m));
        check_word({14'h0, watchdog_op}, op_exp(m, w));
      end
    end
    master_u.xfer(16'h3000, rx);
    check_word(rx, 16'h2C00);
    $display("test modes done");
    // soft reset: not on read-only frames, once per write, once per pin rise
    n = pulses;
    master_u.xfer(16'h1080, rx);
    check_word(16'(pulses - n), 16'h0000);
    master_u.xfer(16'h0480, rx);
    check_word(16'(pulses - n), 16'h0001);
    set_pins(5'b10101);
    check_word(16'(pulses - n), 16'h0002);
    check_word({14'h0, watchdog_op}, 16'h0000);
    master_u.xfer(16'h1000, rx);
    check_word(rx & 16'h0080, 16'h0080);
    $display("test soft_reset done");
    // reset in mid-run restores the period code
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    check_word({13'h0, nominal_period_code}, 16'h0004);
    check_word({14'h0, operating_mode_select}, 16'h0000);
    $display("test second_reset done");
    report_and_stop();
  end
endmodule : testbench
